// ### shared/vih_regs.svh
// Timing counts and field widths for the bus interrupt handler
`ifndef VIH_REGS_SVH
`define VIH_REGS_SVH
`define VIH_NUM_LEVELS      7
`define VIH_LEVEL_W         3
`define VIH_VECTOR_W        8
`define VIH_ACK_TIMEOUT_US  64
`define VIH_CLK_MHZ         10
`define VIH_ACK_TIMEOUT_CYC (`VIH_ACK_TIMEOUT_US * `VIH_CLK_MHZ)
`define VIH_SYS_LEVEL_BASE  4'h8
`endif

// ### shared/vih_pkg.sv
// Types used by the handler end and the bench
package vih_pkg;
  typedef enum logic [2:0] {
    VIH_IDLE,
    VIH_NOTIFY,
    VIH_ARB,
    VIH_ACK,
    VIH_RELEASE
  } vih_state_t;
  typedef logic [2:0] vih_level_t;
  typedef logic [7:0] vih_vector_t;
endpackage

// ### shared/vih_bus_if.sv
// Interrupt request and acknowledge wires between handler and interrupter slots
`timescale 1ns/10ps
`default_nettype none
interface vih_bus_if #(parameter int SLOTS = 4);
  // Request lines, active low, per level 1..7 as open-drain per slot
  logic [7:1]       irq_n_o [SLOTS];
  logic [7:1]       irq_n_oe[SLOTS];
  logic [7:1]       irq_n;
  // Acknowledge strobe and level code from the handler
  logic             iack_n;
  logic [3:1]       addr;
  // Daisy chain: iack_in_n of slot 0 fed by handler strobe
  logic [SLOTS-1:0] iack_in_n;
  logic [SLOTS-1:0] iack_out_n;
  // Status/ID byte and its acknowledge
  logic [7:0]       data_o  [SLOTS];
  logic [SLOTS-1:0] data_oe;
  logic [7:0]       data;
  logic [SLOTS-1:0] dtack_n;
  logic             dtack_all_n;
  // Wire resolution, open drain for request and answer lines; status byte from the highest enabled slot
  always_comb begin
    irq_n = 7'h7F;
    data = 8'hFF;
    for (int s = 0; s < SLOTS; s++) begin
      irq_n = irq_n & ~irq_n_oe[s];
      if (data_oe[s]) begin
        data = data_o[s];
      end
    end
    dtack_all_n = &dtack_n;
  end
  always_comb begin
    iack_in_n[0] = iack_n;
    for (int s = 1; s < SLOTS; s++) begin
      iack_in_n[s] = iack_out_n[s-1];
    end
  end
  modport handler (input irq_n, input data, input dtack_all_n, output iack_n, output addr);
  modport slot (input irq_n, input iack_n, input addr, input iack_in_n, input data,
                output irq_n_o, output irq_n_oe, output iack_out_n, output data_o,
                output data_oe, output dtack_n);
endinterface
`default_nettype wire

// ### hw/vih_handler.sv
// Handler end: ranks bus interrupt levels and runs the acknowledge cycle
`timescale 1ns/10ps
`default_nettype none
`include "vih_regs.svh"
module vih_handler #(
  parameter int ACK_TIMEOUT_CYC = `VIH_ACK_TIMEOUT_CYC
) (
  // Clock and reset
  input  wire logic         ref_clk,
  input  wire logic         rst_b,
  // Bus side
  vih_bus_if.handler        bus,
  // Processor side
  output logic              cpu_irq,
  output logic [3:0]        cpu_sys_level,
  input  wire logic         cpu_iack,
  input  wire logic         bus_grant,
  output logic              bus_request,
  output logic              vec_valid,
  output vih_pkg::vih_vector_t vec_data,
  output logic              ack_error
);
  vih_pkg::vih_state_t  state_reg;
  logic [7:1]           irq_s1_reg;
  logic [7:1]           irq_s2_reg;
  logic [7:0]           data_s1_reg;
  logic [7:0]           data_s2_reg;
  logic                 dtack_s1_reg;
  logic                 dtack_s2_reg;
  vih_pkg::vih_level_t  win_level_next;
  vih_pkg::vih_level_t  cur_level_reg;
  logic [15:0]          tmo_reg;
  logic                 iack_n_reg;
  logic [3:1]           addr_reg;
  logic                 answer_seen;
  logic                 timeout_hit;

  // Two-stage sync of the request pins, one pair of flops per level
  for (genvar l = 1; l <= 7; l++) begin : g_irq_sync
    always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
        irq_s1_reg[l] <= 1'h1;
        irq_s2_reg[l] <= 1'h1;
      end else begin
        irq_s1_reg[l] <= bus.irq_n[l];
        irq_s2_reg[l] <= irq_s1_reg[l];
      end
    end
  end

  // Two-stage sync of the status byte
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      data_s1_reg <= 8'hFF;
      data_s2_reg <= 8'hFF;
    end else begin
      data_s1_reg <= bus.data;
      data_s2_reg <= data_s1_reg;
    end
  end

  // Two-stage sync of the answer strobe
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      dtack_s1_reg <= 1'h1;
      dtack_s2_reg <= 1'h1;
    end else begin
      dtack_s1_reg <= bus.dtack_all_n;
      dtack_s2_reg <= dtack_s1_reg;
    end
  end

  // Highest pending level wins; slot order is settled by the daisy chain
  always_comb begin
    win_level_next = 3'h0;
    for (int l = 1; l <= 7; l++) begin
      if (!irq_s2_reg[l]) begin
        win_level_next = 3'(l);
      end
    end
  end

  // Answer and timeout seen by the sequence
  assign answer_seen = !dtack_s2_reg;
  assign timeout_hit = (tmo_reg == 16'(ACK_TIMEOUT_CYC));

  // Acknowledge sequence
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg     <= vih_pkg::VIH_IDLE;
      cur_level_reg <= 3'h0;
    end else begin
      case (state_reg)
        vih_pkg::VIH_IDLE: begin
          if (win_level_next != 3'h0) begin
            cur_level_reg <= win_level_next;
            state_reg     <= vih_pkg::VIH_NOTIFY;
          end
        end
        vih_pkg::VIH_NOTIFY: begin
          if (cpu_iack) begin
            state_reg <= vih_pkg::VIH_ARB;
          end
        end
        vih_pkg::VIH_ARB: begin
          if (bus_grant) begin
            state_reg <= vih_pkg::VIH_ACK;
          end
        end
        vih_pkg::VIH_ACK: begin
          if (answer_seen || timeout_hit) begin
            state_reg <= vih_pkg::VIH_RELEASE;
          end
        end
        vih_pkg::VIH_RELEASE: begin
          if (dtack_s2_reg) begin
            state_reg <= vih_pkg::VIH_IDLE;
          end
        end
        default: state_reg <= vih_pkg::VIH_IDLE;
      endcase
    end
  end

  // Answer timeout, counts only while the strobe is out
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      tmo_reg <= 16'h0;
    end else if (state_reg == vih_pkg::VIH_ACK) begin
      tmo_reg <= tmo_reg + 16'h1;
    end else begin
      tmo_reg <= 16'h0;
    end
  end

  // Bus ownership request while arbitrating
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      bus_request <= 1'h0;
    end else begin
      bus_request <= (state_reg == vih_pkg::VIH_ARB);
    end
  end

  // Level code, loaded on grant and held through the strobe
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      addr_reg <= 3'h0;
    end else if (state_reg == vih_pkg::VIH_ARB && bus_grant) begin
      addr_reg <= cur_level_reg;
    end
  end

  // Strobe low for the whole answer wait; slot order comes from the chain
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      iack_n_reg <= 1'h1;
    end else begin
      iack_n_reg <= !(state_reg == vih_pkg::VIH_ACK);
    end
  end
  assign bus.iack_n = iack_n_reg;
  assign bus.addr   = addr_reg;

  // Processor notice and the mapped system level
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cpu_irq       <= 1'h0;
      cpu_sys_level <= 4'h0;
    end else begin
      cpu_irq       <= (state_reg == vih_pkg::VIH_NOTIFY);
      cpu_sys_level <= `VIH_SYS_LEVEL_BASE + {1'h0, cur_level_reg};
    end
  end

  // Status byte handed over once per answered cycle
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      vec_valid <= 1'h0;
      vec_data  <= 8'h00;
    end else begin
      vec_valid <= (state_reg == vih_pkg::VIH_ACK) && answer_seen;
      if (state_reg == vih_pkg::VIH_ACK && answer_seen) begin
        vec_data <= data_s2_reg;
      end
    end
  end

  // Timeout pulse when no board answered
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ack_error <= 1'h0;
    end else begin
      ack_error <= (state_reg == vih_pkg::VIH_ACK) && !answer_seen && timeout_hit;
    end
  end
endmodule // vih_handler
`default_nettype wire

// ### hw/vih_interrupter.sv
// Interrupter end: one board per slot, requests and answers with a vector
`timescale 1ns/10ps
`default_nettype none
module vih_interrupter #(
  parameter int SLOT = 0
) (
  // Clock and reset
  input  wire logic         ref_clk,
  input  wire logic         rst_b,
  // Bus side
  vih_bus_if.slot           bus,
  // User side
  input  wire logic         req,
  input  wire logic [2:0]   req_level,
  input  wire logic [7:0]   req_vector,
  output logic              busy,
  output logic              served
);
  logic       pend_reg;
  logic [2:0] lvl_reg;
  logic [7:0] vec_reg;
  logic [2:0] inn_s_reg;
  logic [3:1] addr_s1_reg;
  logic [3:1] addr_s2_reg;
  logic       answer_reg;
  logic       pass_reg;
  logic       match;

  // Sync of chain inputs; strobe is taken as seen once the second and third stages both read low
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      inn_s_reg   <= 3'h7;
      addr_s1_reg <= 3'h0;
      addr_s2_reg <= 3'h0;
    end else begin
      inn_s_reg   <= {inn_s_reg[1:0], bus.iack_in_n[SLOT]};
      addr_s1_reg <= bus.addr;
      addr_s2_reg <= addr_s1_reg;
    end
  end
  assign match = pend_reg && (addr_s2_reg == lvl_reg);

  // Request, answer and chain pass-on
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pend_reg   <= 1'h0;
      lvl_reg    <= 3'h0;
      vec_reg    <= 8'h00;
      answer_reg <= 1'h0;
      pass_reg   <= 1'h0;
      served     <= 1'h0;
    end else begin
      served <= 1'h0;
      if (!pend_reg && req && req_level != 3'h0) begin
        pend_reg <= 1'h1;
        lvl_reg  <= req_level;
        vec_reg  <= req_vector;
      end
      if (!inn_s_reg[2] && inn_s_reg[1] == 1'h0 && !answer_reg && !pass_reg) begin
        if (match) begin
          answer_reg <= 1'h1;
        end else begin
          pass_reg <= 1'h1;
        end
      end
      if (inn_s_reg[2]) begin
        if (answer_reg) begin
          pend_reg <= 1'h0;
          served   <= 1'h1;
        end
        answer_reg <= 1'h0;
        pass_reg   <= 1'h0;
      end
    end
  end

  // Bus drive from flops
  always_comb begin
    for (int l = 1; l <= 7; l++) begin
      bus.irq_n_o[SLOT][l]  = 1'h0;
      bus.irq_n_oe[SLOT][l] = pend_reg && !answer_reg && (lvl_reg == 3'(l));
    end
    bus.data_o[SLOT]     = vec_reg;
    bus.data_oe[SLOT]    = answer_reg;
    bus.dtack_n[SLOT]    = !answer_reg;
    bus.iack_out_n[SLOT] = !pass_reg;
  end
  assign busy = pend_reg;
endmodule // vih_interrupter
`default_nettype wire

// ### bench/vih_bus_monitor.sv
// Protocol checker on the handler to slot bus wires
`timescale 1ns/10ps
`default_nettype none
module vih_bus_monitor (
  // Clock and reset
  input wire logic       ref_clk,
  input wire logic       rst_b,
  // Bus wires
  input wire logic [7:1] irq_n,
  input wire logic       iack_n,
  input wire logic [3:1] addr,
  input wire logic       dtack_all_n
);
  localparam int T_MAX = 60;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  AST_LEVEL_PENDING: assert property ($fell(iack_n) |-> addr != 3'h0 && !irq_n[addr])
    else $error("strobe level not pending");
  AST_HIGHEST: assert property ($fell(iack_n) |-> ((~irq_n) >> addr) == 7'h00)
    else $error("higher level pending at strobe");
  AST_ADDR_HELD: assert property (!iack_n |=> iack_n || $stable(addr))
    else $error("level code moved under strobe");
  AST_STROBE_MIN: assert property ($fell(iack_n) |=> !iack_n)
    else $error("strobe too short for chain");
  AST_STROBE_BOUND: assert property ($fell(iack_n) |-> ##[2:T_MAX] iack_n)
    else $error("strobe never ended");
  AST_ANSWER_ENDS: assert property ($fell(dtack_all_n) && !iack_n |-> ##[1:4] iack_n)
    else $error("strobe held after answer");
  AST_WAIT_RELEASE: assert property (iack_n && !dtack_all_n |=> iack_n)
    else $error("new strobe before answer released");
  AST_IDLE_QUIET: assert property ((irq_n == 7'h7F) [*6] |-> iack_n)
    else $error("strobe with no request");
  AST_ANSWER_IN_CYCLE: assert property ($fell(dtack_all_n) |-> !iack_n)
    else $error("answer outside strobe");
  cover property ($fell(iack_n) && addr == 3'h7);
  cover property ($fell(iack_n) && addr == 3'h1);
  cover property ($fell(dtack_all_n));
endmodule // vih_bus_monitor
`default_nettype wire

// ### bench/vih_bench.sv
// Bench: handler and four interrupter slots on one bus
`timescale 1ns/10ps
`default_nettype none
module vih_bench;
  logic                 ref_clk;
  logic                 rst_b;
  logic                 cpu_iack;
  logic                 bus_grant;
  logic                 cpu_irq;
  logic                 bus_request;
  logic                 vec_valid;
  logic                 ack_error;
  logic [3:0]           cpu_sys_level;
  logic [3:0]           req;
  logic [3:0]           pend;
  wire logic [3:0]      busy;
  wire logic [3:0]      served;
  logic [2:0]           lvl [4];
  logic [7:0]           vec [4];
  vih_pkg::vih_vector_t vec_data;
  int                   fail_count = 0;
  int                   total_checks = 0;
  int                   seed = 32'hE8707112;
  vih_bus_if #(.SLOTS(4)) bus ();
  vih_handler #(.ACK_TIMEOUT_CYC(50)) vih_handler_inst (.ref_clk(ref_clk), .rst_b(rst_b),
    .bus(bus), .cpu_irq(cpu_irq), .cpu_sys_level(cpu_sys_level), .cpu_iack(cpu_iack),
    .bus_grant(bus_grant), .bus_request(bus_request), .vec_valid(vec_valid),
    .vec_data(vec_data), .ack_error(ack_error));
  for (genvar s = 0; s < 4; s++) begin : g_slot
    vih_interrupter #(.SLOT(s)) vih_interrupter_inst (.ref_clk(ref_clk), .rst_b(rst_b),
      .bus(bus), .req(req[s]), .req_level(lvl[s]), .req_vector(vec[s]), .busy(busy[s]),
      .served(served[s]));
  end
  vih_bus_monitor vih_bus_monitor_inst (.ref_clk(ref_clk), .rst_b(rst_b), .irq_n(bus.irq_n),
    .iack_n(bus.iack_n), .addr(bus.addr), .dtack_all_n(bus.dtack_all_n));
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  // Processor side answers every request
  always @(negedge ref_clk) begin
    cpu_iack <= cpu_irq;
    bus_grant <= bus_request;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Highest level wins, lowest slot on a tie
  function automatic int pick();
    int b = 0;
    for (int s = 3; s >= 0; s--)
      if (pend[s] && (!pend[b] || lvl[s] >= lvl[b])) b = s;
    return b;
  endfunction
  task automatic serve();
    int b = pick();
    int n = 0;
    chk({7'h00, busy[b]}, 8'h01);
    while (cpu_irq !== 1'b1 && n < 200) begin
      @(negedge ref_clk);
      n++;
    end
    if (n >= 200) fail_count++;
    chk({4'h0, cpu_sys_level}, 8'h08 + lvl[b]);
    while (vec_valid !== 1'b1 && n < 400) begin
      @(negedge ref_clk);
      chk({7'h00, ack_error}, 8'h00);
      n++;
    end
    if (n >= 400) fail_count++;
    chk(vec_data, vec[b]);
    while (served[b] !== 1'b1 && n < 450) begin
      @(negedge ref_clk);
      n++;
    end
    chk({7'h00, busy[b]}, 8'h00);
    pend[b] = 1'b0;
  endtask
  initial begin
    rst_b = 1'b0;
    req = 4'h0;
    for (int s = 0; s < 4; s++) begin
      lvl[s] = 3'h0;
      vec[s] = 8'h00;
    end
    repeat (2) @(negedge ref_clk);
    rst_b = 1'b1;
    for (int r = 0; r < 22; r++) begin
      pend = (r < 2) ? 4'hF : 4'(1 + {$random(seed)} % 15);
      for (int s = 0; s < 4; s++) begin
        lvl[s] = (r == 0) ? 3'h7 : (r == 1) ? 3'(s + 1) : 3'(1 + {$random(seed)} % 7);
        vec[s] = 8'($random(seed));
      end
      req = pend;
      @(negedge ref_clk);
      req = 4'h0;
      while (pend != 4'h0) serve();
      repeat (8) @(negedge ref_clk);
    end
    test_done();
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    fail_count++;
    test_done();
  end
endmodule // vih_bench
`default_nettype wire
